// ===== bench/led_pwm_current_control_bench.sv
// self-checking bench for the led pwm and current control block
`timescale 1ns/10ps
`default_nettype none

module led_pwm_current_control_bench;
    logic        MCLK = 1'b0;
    logic        RST_N = 1'b0;
    logic [5:0]  AWADDR = 6'h00, ARADDR = 6'h00;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic [3:0]  WSTRB = 4'hf;
    logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, DIFF_CLOCK_IN_POS, DIFF_CLOCK_IN_NEG;
    logic [1:0]  BRESP, RRESP;
    logic [2:0]  SINK_OUTPUT_OF_CHANNEL, exp_sink;
    logic [13:0] CURRENT_LEVEL_0, CURRENT_LEVEL_1, CURRENT_LEVEL_2;
    int          errors = 0, checks_done = 0, on_cycles;
    int          trim_m[3], saved_m[3] = '{127, 127, 127}, lvl_m[3], duty_m[3], scale_m;

    always #4 MCLK = ~MCLK;

    led_pwm_current_control dut_u (
        .MCLK(MCLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .DIFF_CLOCK_IN_POS(DIFF_CLOCK_IN_POS), .DIFF_CLOCK_IN_NEG(DIFF_CLOCK_IN_NEG),
        .SINK_OUTPUT_OF_CHANNEL(SINK_OUTPUT_OF_CHANNEL), .CURRENT_LEVEL_0(CURRENT_LEVEL_0),
        .CURRENT_LEVEL_1(CURRENT_LEVEL_1), .CURRENT_LEVEL_2(CURRENT_LEVEL_2)
    );

    upstream_ctrl_model link_u (
        .mclk(MCLK), .clk_pos(DIFF_CLOCK_IN_POS), .clk_neg(DIFF_CLOCK_IN_NEG)
    );

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp_bus(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input logic [13:0] got, input logic [13:0] exp);
        cmp_bus({18'h0, got}, {18'h0, exp});
    endtask

    task automatic bus_wait_end(input logic hs);
        if (!hs)
        begin
            errors++;
            give_verdict();
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        logic hs;
        int   n;
        hs = 1'b0;
        n = 0;
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        do
        begin
            @(posedge MCLK);
            n++;
            if (AWREADY === 1'b1)
                AWVALID <= 1'b0;
            if (WREADY === 1'b1)
                WVALID <= 1'b0;
            hs = (BVALID === 1'b1) && (BREADY === 1'b1);
            if (hs)
                cmp_bus({30'h0, BRESP}, {30'h0, er});
            BREADY <= !hs;
        end
        while (!hs && n < 200);
        bus_wait_end(hs);
    endtask

    // rready comes one cycle late so the held answer is exercised
    task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic hs;
        int   n;
        hs = 1'b0;
        n = 0;
        ARADDR <= a;
        ARVALID <= 1'b1;
        do
        begin
            @(posedge MCLK);
            n++;
            if (ARREADY === 1'b1)
                ARVALID <= 1'b0;
            hs = (RVALID === 1'b1) && (RREADY === 1'b1);
            if (hs)
                cmp_bus({RRESP, RDATA[29:0]}, {er, ed[29:0]});
            if (hs)
                cmp_bus({30'h0, RDATA[31:30]}, {30'h0, ed[31:30]});
            RREADY <= (n > 1) && !hs;
        end
        while (!hs && n < 200);
        bus_wait_end(hs);
    endtask

    task automatic chk_levels;
        repeat (2) @(posedge MCLK);
        cmp_pin(CURRENT_LEVEL_0, 14'(lvl_m[0]));
        cmp_pin(CURRENT_LEVEL_1, 14'(lvl_m[1]));
        cmp_pin(CURRENT_LEVEL_2, 14'(lvl_m[2]));
    endtask

    task automatic latch(input logic [31:0] ctrl);
        wr(led_pwm_pkg::OFS_CTRL, ctrl | 32'h1, led_pwm_pkg::RESP_OKAY);
        for (int c = 0; c < 3; c++)
            lvl_m[c] = trim_m[c] * scale_m;
    endtask

    task automatic do_reset;
        RST_N <= 1'b0;
        repeat (10) @(posedge MCLK);
        RST_N <= 1'b1;
        scale_m = 127;
        for (int c = 0; c < 3; c++)
        begin
            trim_m[c] = saved_m[c];
            lvl_m[c] = saved_m[c] * 127;
            duty_m[c] = 0;
        end
        repeat (8) @(posedge MCLK);
    endtask

    initial
    begin
        void'($urandom(32'h4344));
        do_reset();
        chk_levels();
        cmp_pin({11'h0, SINK_OUTPUT_OF_CHANNEL}, 14'h0);
        rd(led_pwm_pkg::OFS_SCALE, 32'h7f, led_pwm_pkg::RESP_OKAY);
        for (int c = 0; c < 3; c++)
            rd(led_pwm_pkg::OFS_DUTY0 + 6'(4 * c), 32'h0, led_pwm_pkg::RESP_OKAY);
        rd(6'h24, 32'h0, led_pwm_pkg::RESP_SLVERR);
        wr(6'h24, 32'h1, led_pwm_pkg::RESP_SLVERR);
        wr(led_pwm_pkg::OFS_STATUS, 32'h0, led_pwm_pkg::RESP_OKAY);
        // boundary codes first, then random ones
        for (int k = 0; k < 4; k++)
        begin
            for (int c = 0; c < 3; c++)
            begin
                trim_m[c] = (k == 0) ? 0 : (k == 1) ? 127 : int'($urandom % 128);
                wr(led_pwm_pkg::OFS_TRIM0 + 6'(4 * c), 32'(trim_m[c]), 2'h0);
                rd(led_pwm_pkg::OFS_TRIM0 + 6'(4 * c), 32'(trim_m[c]), 2'h0);
            end
            scale_m = (k == 1) ? 0 : int'($urandom % 128);
            wr(led_pwm_pkg::OFS_SCALE, 32'(scale_m), 2'h0);
            chk_levels();
            latch(32'h0);
            chk_levels();
        end
        // upper byte lanes only: the trim byte must not move
        WSTRB <= 4'he;
        wr(led_pwm_pkg::OFS_TRIM0, 32'h55, 2'h0);
        WSTRB <= 4'hf;
        rd(led_pwm_pkg::OFS_TRIM0, 32'(trim_m[0]), 2'h0);
        wr(led_pwm_pkg::OFS_CTRL, 32'h2, 2'h0);
        saved_m = trim_m;
        repeat (6) @(posedge MCLK);
        wr(led_pwm_pkg::OFS_SCALE, 32'h5, 2'h0);
        do_reset();
        chk_levels();
        rd(led_pwm_pkg::OFS_SCALE, 32'h7f, 2'h0);
        duty_m = '{0, 1, 2 + int'($urandom % 5)};
        for (int c = 0; c < 3; c++)
            wr(led_pwm_pkg::OFS_DUTY0 + 6'(4 * c), 32'(duty_m[c]), 2'h0);
        latch(32'h200);
        for (int n = 1; n <= 7; n++)
        begin
            link_u.send_tick(4 + n % 3);
            for (int c = 0; c < 3; c++)
                exp_sink[c] = (duty_m[c] != 0) && (n <= duty_m[c]);
            cmp_pin({11'h0, SINK_OUTPUT_OF_CHANNEL}, {11'h0, exp_sink});
        end
        rd(led_pwm_pkg::OFS_STATUS, 32'h0001_0007, 2'h0);
        wr(led_pwm_pkg::OFS_DUTY0, 32'h2, 2'h0);
        latch(32'h0);
        on_cycles = 0;
        repeat (400)
        begin
            @(posedge MCLK);
            if (SINK_OUTPUT_OF_CHANNEL[0] === 1'b1)
                on_cycles++;
        end
        cmp_bus(32'(on_cycles), 32'(2 * led_pwm_pkg::DUTY_TICK_CYCLES));
        give_verdict();
    end
endmodule // led_pwm_current_control_bench

`default_nettype wire

// ===== bench/led_pwm_props_properties.sv
// port-level checks for the led pwm and current control block
`timescale 1ns/10ps
`default_nettype none

module led_pwm_props (
    input wire logic        MCLK,
    input wire logic        RST_N,
    input wire logic        AWVALID,
    input wire logic        AWREADY,
    input wire logic        WVALID,
    input wire logic        WREADY,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic [5:0]  ARADDR,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP,
    input wire logic        RVALID,
    input wire logic        RREADY,
    input wire logic [13:0] CURRENT_LEVEL_0,
    input wire logic [13:0] CURRENT_LEVEL_1,
    input wire logic [13:0] CURRENT_LEVEL_2
);
    logic [3:0] boot_r;

    // counts out the trim load after reset, when levels may change unasked
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
            boot_r <= 4'h0;
        else if (boot_r != 4'hf)
            boot_r <= boot_r + 4'h1;
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    sequence s_both_taken;
        AWVALID && AWREADY && WVALID && WREADY;
    endsequence

    sequence s_write_done;
        !AWREADY && !WREADY && !BVALID ##1 BVALID;
    endsequence

    a_write_answer: assert property (s_both_taken |=> s_write_done)
        else $error("write answer late or early");
    a_write_reopen: assert property (BVALID && BREADY |=> AWREADY && WREADY && !BVALID)
        else $error("write channel not reopened");
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
        else $error("read answer not next cycle");
    a_read_reopen: assert property (RVALID && RREADY |=> ARREADY && !RVALID)
        else $error("read channel not reopened");
    a_read_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read answer dropped or changed");
    a_unmapped_read: assert property (
        ARVALID && ARREADY && ARADDR > led_pwm_pkg::OFS_STATUS
        |=> RRESP == led_pwm_pkg::RESP_SLVERR && RDATA == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_read: assert property (
        ARVALID && ARREADY && ARADDR <= led_pwm_pkg::OFS_STATUS && ARADDR[1:0] == 2'h0
        |=> RRESP == led_pwm_pkg::RESP_OKAY)
        else $error("mapped read refused");
    a_level_source: assert property (
        $changed({CURRENT_LEVEL_0, CURRENT_LEVEL_1, CURRENT_LEVEL_2})
        |-> BVALID || $past(BVALID) || boot_r < 4'hc)
        else $error("current level changed without a latch");
    a_level_bound: assert property (
        CURRENT_LEVEL_0 <= 14'h3f01 && CURRENT_LEVEL_1 <= 14'h3f01
        && CURRENT_LEVEL_2 <= 14'h3f01)
        else $error("current level above full scale");
endmodule // led_pwm_props

bind led_pwm_current_control led_pwm_props props_u (
    .MCLK(MCLK), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
    .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .CURRENT_LEVEL_0(CURRENT_LEVEL_0), .CURRENT_LEVEL_1(CURRENT_LEVEL_1),
    .CURRENT_LEVEL_2(CURRENT_LEVEL_2)
);

`default_nettype wire

// ===== bench/upstream_ctrl_model.sv
// upstream controller model making the differential shift clock
`timescale 1ns/10ps
`default_nettype none

module upstream_ctrl_model (
    input  wire logic mclk,
    output logic      clk_pos,
    output logic      clk_neg
);
    // shift clock stands low between frames
    initial
    begin
        clk_pos = 1'b0;
        clk_neg = 1'b1;
    end

    // one shift-clock period; legs always complementary, length varies
    task automatic send_tick(input int half);
        clk_pos <= 1'b1;
        clk_neg <= 1'b0;
        repeat (half) @(posedge mclk);
        clk_pos <= 1'b0;
        clk_neg <= 1'b1;
        repeat (half) @(posedge mclk);
    endtask
endmodule // upstream_ctrl_model

`default_nettype wire

// ===== hdl/led_pwm_current_control.sv
// three-channel duty generator with trim and scale current codes
`timescale 1ns/10ps
`default_nettype none

module led_pwm_current_control (
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic [5:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic      [1:0]  BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [5:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic      [31:0] RDATA,
    output logic      [1:0]  RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    input  wire logic        DIFF_CLOCK_IN_POS,
    input  wire logic        DIFF_CLOCK_IN_NEG,
    output logic      [2:0]  SINK_OUTPUT_OF_CHANNEL,
    output logic      [13:0] CURRENT_LEVEL_0,
    output logic      [13:0] CURRENT_LEVEL_1,
    output logic      [13:0] CURRENT_LEVEL_2
);

    typedef struct packed {
        led_pwm_pkg::nvm_state_t st;
        logic [1:0]              idx;
        logic [1:0]              rd_idx;
        logic                    rd_pend;
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [1:0]              rresp;
        logic [31:0]             rdata;
        logic                    aw_have;
        logic                    w_have;
        logic [5:0]              aw_addr;
        logic [31:0]             w_data;
        logic [3:0]              w_strb;
        logic                    clk_sel;
        logic [6:0]              scale;
        logic [2:0][6:0]         trim;
        logic [2:0][11:0]        duty;
        logic [7:0]              osc_cnt;
        logic                    sck_prev;
        logic                    armed;
        logic                    running;
        logic [11:0]             cnt;
        logic [2:0]              sink;
        logic [2:0][13:0]        level;
    } ctl_r_t;

    ctl_r_t r;
    ctl_r_t n;

    logic       mem_re;
    logic       mem_we;
    logic [1:0] mem_waddr;
    logic [6:0] mem_wdata;
    logic [6:0] mem_rdata;

    // load walks the three words, store writes them back one a cycle
    assign mem_re    = (r.st == led_pwm_pkg::ST_LOAD) && (r.idx < 2'd3);
    assign mem_we    = (r.st == led_pwm_pkg::ST_STORE);
    assign mem_waddr = r.idx;
    assign mem_wdata = r.trim[r.idx];

    trim_nvm #(
        .W     (led_pwm_pkg::TRIM_W),
        .DEPTH (led_pwm_pkg::NUM_CH),
        .INIT  (led_pwm_pkg::TRIM_INIT)
    ) u_nvm (
        .clk   (MCLK),
        .rst_n (RST_N),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .re    (mem_re),
        .raddr (r.idx),
        .rdata (mem_rdata)
    );

    // byte-lane merge of a write into a register's old value
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [31:0] lane_mask;
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (data & lane_mask) | (old & ~lane_mask);
    endfunction

    logic        wr_go;
    logic        latch;
    logic        store_req;
    logic        tick;
    logic        tick_int;
    logic        sck_hi;
    logic [31:0] wr_val;
    logic [11:0] cnt_inc;

    always_comb
    begin
        n         = r;
        latch     = 1'b0;
        store_req = 1'b0;
        wr_val    = '0;
        cnt_inc   = r.cnt + 12'h001;

        // write channel: address and data taken in either order
        if (r.awready && AWVALID)
        begin
            n.aw_have = 1'b1;
            n.aw_addr = AWADDR;
        end
        if (r.wready && WVALID)
        begin
            n.w_have = 1'b1;
            n.w_data = WDATA;
            n.w_strb = WSTRB;
        end
        if (r.bvalid && BREADY)
        begin
            n.bvalid = 1'b0;
        end

        wr_go = r.aw_have && r.w_have && !r.bvalid;
        if (wr_go)
        begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = led_pwm_pkg::RESP_OKAY;
            case (r.aw_addr)
                led_pwm_pkg::OFS_CTRL:
                begin
                    wr_val    = merge({22'h0, r.clk_sel, 9'h0}, r.w_data, r.w_strb);
                    n.clk_sel = wr_val[led_pwm_pkg::CTRL_CLKSEL_BIT];
                    latch     = wr_val[led_pwm_pkg::CTRL_LATCH_BIT];
                    store_req = wr_val[led_pwm_pkg::CTRL_STORE_BIT];
                end
                led_pwm_pkg::OFS_SCALE:
                begin
                    // held only in flops, never written to the store
                    wr_val  = merge({25'h0, r.scale}, r.w_data, r.w_strb);
                    n.scale = wr_val[6:0];
                end
                led_pwm_pkg::OFS_TRIM0,
                led_pwm_pkg::OFS_TRIM1,
                led_pwm_pkg::OFS_TRIM2:
                begin
                    wr_val = merge({25'h0, r.trim[r.aw_addr[4:2] - 3'h2]},
                                   r.w_data, r.w_strb);
                    n.trim[r.aw_addr[4:2] - 3'h2] = wr_val[6:0];
                end
                led_pwm_pkg::OFS_DUTY0,
                led_pwm_pkg::OFS_DUTY1,
                led_pwm_pkg::OFS_DUTY2:
                begin
                    wr_val = merge({20'h0, r.duty[r.aw_addr[4:2] - 3'h5]},
                                   r.w_data, r.w_strb);
                    n.duty[r.aw_addr[4:2] - 3'h5] = wr_val[11:0];
                end
                led_pwm_pkg::OFS_STATUS: n.bresp = led_pwm_pkg::RESP_OKAY;
                default:                 n.bresp = led_pwm_pkg::RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_have && !n.bvalid;
        n.wready  = !n.w_have && !n.bvalid;

        // read channel: one read outstanding, answered the next cycle
        if (r.rvalid && RREADY)
        begin
            n.rvalid  = 1'b0;
            n.arready = 1'b1;
        end
        if (r.arready && ARVALID)
        begin
            n.arready = 1'b0;
            n.rvalid  = 1'b1;
            n.rresp   = led_pwm_pkg::RESP_OKAY;
            n.rdata   = '0;
            case (ARADDR)
                led_pwm_pkg::OFS_CTRL:   n.rdata[led_pwm_pkg::CTRL_CLKSEL_BIT] = r.clk_sel;
                led_pwm_pkg::OFS_SCALE:  n.rdata = {25'h0, r.scale};
                led_pwm_pkg::OFS_TRIM0:  n.rdata = {25'h0, r.trim[0]};
                led_pwm_pkg::OFS_TRIM1:  n.rdata = {25'h0, r.trim[1]};
                led_pwm_pkg::OFS_TRIM2:  n.rdata = {25'h0, r.trim[2]};
                led_pwm_pkg::OFS_DUTY0:  n.rdata = {20'h0, r.duty[0]};
                led_pwm_pkg::OFS_DUTY1:  n.rdata = {20'h0, r.duty[1]};
                led_pwm_pkg::OFS_DUTY2:  n.rdata = {20'h0, r.duty[2]};
                led_pwm_pkg::OFS_STATUS:
                begin
                    n.rdata[led_pwm_pkg::STAT_CNT_LSB +: 12] = r.cnt;
                    n.rdata[led_pwm_pkg::STAT_RUN_BIT]       = r.running;
                    n.rdata[led_pwm_pkg::STAT_BUSY_BIT]      =
                        (r.st != led_pwm_pkg::ST_IDLE);
                end
                default: n.rresp = led_pwm_pkg::RESP_SLVERR;
            endcase
        end

        // nonvolatile trim load after reset, and save on request
        case (r.st)
            led_pwm_pkg::ST_LOAD:
            begin
                if (r.rd_pend)
                begin
                    n.trim[r.rd_idx] = mem_rdata;
                end
                n.rd_pend = (r.idx < 2'd3);
                n.rd_idx  = r.idx;
                if (r.idx < 2'd3)
                begin
                    n.idx = r.idx + 2'd1;
                end
                else if (!r.rd_pend)
                begin
                    n.st  = led_pwm_pkg::ST_IDLE;
                    n.idx = 2'd0;
                end
            end
            led_pwm_pkg::ST_IDLE:
            begin
                if (store_req)
                begin
                    n.st  = led_pwm_pkg::ST_STORE;
                    n.idx = 2'd0;
                end
            end
            led_pwm_pkg::ST_STORE:
            begin
                // trims written during a save go out as they stand
                n.idx = r.idx + 2'd1;
                if (r.idx == 2'd2)
                begin
                    n.st  = led_pwm_pkg::ST_IDLE;
                    n.idx = 2'd0;
                end
            end
            default:
            begin
                n.st  = led_pwm_pkg::ST_IDLE;
                n.idx = 2'd0;
            end
        endcase

        // current codes refresh on a latch or when the power-on load ends
        if (latch || (r.st == led_pwm_pkg::ST_LOAD && n.st == led_pwm_pkg::ST_IDLE))
        begin
            for (int c = 0; c < led_pwm_pkg::NUM_CH; c++)
            begin
                n.level[c] = {7'h0, n.trim[c]} * {7'h0, n.scale};
            end
        end

        // duty tick: free-running divider, or shift-clock rising edge
        sck_hi     = DIFF_CLOCK_IN_POS && !DIFF_CLOCK_IN_NEG;
        n.sck_prev = sck_hi;
        tick_int   = (r.osc_cnt == 8'(led_pwm_pkg::DUTY_TICK_CYCLES - 1));
        n.osc_cnt  = tick_int ? 8'h00 : r.osc_cnt + 8'h01;
        tick       = r.clk_sel ? (sck_hi && !r.sck_prev) : tick_int;

        // a latch restarts the cycle; counting begins at the next tick
        if (latch)
        begin
            n.armed   = 1'b1;
            n.running = 1'b0;
            n.cnt     = 12'h000;
            n.sink    = 3'h0;
        end
        else if (tick && r.armed)
        begin
            n.armed   = 1'b0;
            n.running = 1'b1;
            n.cnt     = 12'h001;
            for (int c = 0; c < led_pwm_pkg::NUM_CH; c++)
            begin
                n.sink[c] = (r.duty[c] != led_pwm_pkg::DUTY_RST);
            end
        end
        else if (tick && r.running)
        begin
            // no auto repeat: the cycle ends after the last code
            if (r.cnt == led_pwm_pkg::DUTY_MAX)
            begin
                n.running = 1'b0;
                n.sink    = 3'h0;
            end
            else
            begin
                n.cnt = cnt_inc;
                for (int c = 0; c < led_pwm_pkg::NUM_CH; c++)
                begin
                    n.sink[c] = r.sink[c] && (cnt_inc <= r.duty[c]);
                end
            end
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            r         <= '0;
            r.st      <= led_pwm_pkg::ST_LOAD;
            r.scale   <= led_pwm_pkg::SCALE_RST;
            r.duty    <= {3{led_pwm_pkg::DUTY_RST}};
            r.awready <= 1'b1;
            r.wready  <= 1'b1;
            r.arready <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    assign AWREADY                = r.awready;
    assign WREADY                 = r.wready;
    assign BVALID                 = r.bvalid;
    assign BRESP                  = r.bresp;
    assign ARREADY                = r.arready;
    assign RVALID                 = r.rvalid;
    assign RRESP                  = r.rresp;
    assign RDATA                  = r.rdata;
    assign SINK_OUTPUT_OF_CHANNEL = r.sink;
    assign CURRENT_LEVEL_0        = r.level[0];
    assign CURRENT_LEVEL_1        = r.level[1];
    assign CURRENT_LEVEL_2        = r.level[2];

endmodule // led_pwm_current_control

`default_nettype wire

// ===== hdl/led_pwm_pkg.sv
// constants and types shared by the led pwm and current control block
`default_nettype none
package led_pwm_pkg;

    // register byte offsets on the axi4-lite slave
    localparam logic [5:0] OFS_CTRL   = 6'h00;
    localparam logic [5:0] OFS_SCALE  = 6'h04;
    localparam logic [5:0] OFS_TRIM0  = 6'h08;
    localparam logic [5:0] OFS_TRIM1  = 6'h0c;
    localparam logic [5:0] OFS_TRIM2  = 6'h10;
    localparam logic [5:0] OFS_DUTY0  = 6'h14;
    localparam logic [5:0] OFS_DUTY1  = 6'h18;
    localparam logic [5:0] OFS_DUTY2  = 6'h1c;
    localparam logic [5:0] OFS_STATUS = 6'h20;

    // control register fields
    localparam int CTRL_LATCH_BIT  = 0;
    localparam int CTRL_STORE_BIT  = 1;
    localparam int CTRL_CLKSEL_BIT = 9;

    // status register fields
    localparam int STAT_CNT_LSB  = 0;
    localparam int STAT_RUN_BIT  = 16;
    localparam int STAT_BUSY_BIT = 17;

    // code widths and values after reset
    localparam int          TRIM_W    = 7;
    localparam int          DUTY_W    = 12;
    localparam int          LEVEL_W   = 14;
    localparam int          NUM_CH    = 3;
    localparam logic [6:0]  SCALE_RST = 7'h7f;
    localparam logic [6:0]  TRIM_INIT = 7'h7f;
    localparam logic [11:0] DUTY_RST  = 12'h000;
    localparam logic [11:0] DUTY_MAX  = 12'hfff;

    // duty tick from the internal oscillator: two oscillator periods
    localparam int OSC_PERIOD_NS    = 200;
    localparam int CLK_PERIOD_NS    = 8;
    localparam int DUTY_TICK_CYCLES = (2 * OSC_PERIOD_NS) / CLK_PERIOD_NS;

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_LOAD  = 3'h1,
        ST_IDLE  = 3'h2,
        ST_STORE = 3'h4
    } nvm_state_t;

endpackage

`default_nettype wire

// ===== hdl/trim_nvm.sv
// nonvolatile store for the per-channel trim codes
`timescale 1ns/10ps
`default_nettype none

module trim_nvm #(
    parameter int         W     = 7,
    parameter int         DEPTH = 3,
    parameter logic [6:0] INIT  = 7'h7f
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [W-1:0]             wdata,
    input  wire logic                     re,
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [W-1:0]             rdata
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0]            rd_data;
    } nvm_r_t;

    // contents survive reset; only the read register is cleared
    nvm_r_t r = '{mem: {DEPTH{INIT[W-1:0]}}, rd_data: '0};
    nvm_r_t n;

    always_comb
    begin
        n = r;
        if (we)
        begin
            n.mem[waddr] = wdata;
        end
        if (re)
        begin
            n.rd_data = r.mem[raddr];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            r.rd_data <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign rdata = r.rd_data;

endmodule // trim_nvm

`default_nettype wire
